// ### include/dbm_defs.svh
`ifndef DBM_DEFS_SVH
`define DBM_DEFS_SVH

// =====================================================================
// Envelope structure.
`define DBM_ROWS 9
`define DBM_ROW_DATA 621
`define DBM_CTRL_BITS 5
`define DBM_OPP_COL 5
`define DBM_ROW_LEN 627
`define DBM_FIXED_DATA 5589
`define DBM_OPP_NOMINAL 3'h3
`define DBM_OPP_NEG 3'h4
`define DBM_OPP_POS 3'h2

// =====================================================================
// Envelope timing at 100 MHz.
`define DBM_ENV_PER_SEC 8000
`define DBM_CLK_NS 10
`define DBM_FRAME_NS (1000000000 / `DBM_ENV_PER_SEC)

// =====================================================================
// Elastic store.
`define DBM_STORE_AW 6
`define DBM_STORE_DEPTH 64
`define DBM_STORE_HALF 7'h20
`define DBM_STORE_BAND 7'h08

// =====================================================================
// Output buffer word: data bit in bit 0, kind in bits 2:1.
`define DBM_WORD_W 3

`endif

// ### include/dbm_pkg.sv
package dbm_pkg;
    typedef enum logic [1:0] {
        KIND_CTRL,
        KIND_OPP_DATA,
        KIND_OPP_STUFF,
        KIND_DATA
    } dbm_kind_type;

    typedef enum logic {
        MAP_IDLE,
        MAP_RUN
    } dbm_map_state_type;
endpackage

// ### src/dbm_pair_buffer.sv
`timescale 1ns/1ps
`default_nettype none
`include "dbm_defs.svh"

module dbm_pair_buffer (
    input wire logic sys_clk_in, // System clock.
    input wire logic srst_in, // Synchronous reset, active high.
    input wire logic ce_in, // Clock enable.
    input wire logic [`DBM_WORD_W-1:0] in_data_in, // Word to store.
    input wire logic in_valid_in, // Word offered.
    output logic in_ready_out, // Room for a word.
    output logic [`DBM_WORD_W-1:0] out_data_out, // Oldest word.
    output logic out_valid_out, // Oldest word present.
    input wire logic out_ready_in // Receiver takes the word.
);
    logic [`DBM_WORD_W-1:0] mem [0:1];
    logic [`DBM_WORD_W-1:0] next_mem [0:1];
    logic wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [1:0] count, next_count;
    logic push, pop;

    assign in_ready_out = (count != 2'h2);
    assign out_valid_out = (count != 2'h0);
    assign out_data_out = mem[rd_ptr];

    always_comb begin
        push = in_valid_in && in_ready_out;
        pop = out_valid_out && out_ready_in;
        next_mem[0] = mem[0];
        next_mem[1] = mem[1];
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count = count;
        if (push) begin
            next_mem[wr_ptr] = in_data_in;
            next_wr_ptr = ~wr_ptr;
        end
        if (pop) begin
            next_rd_ptr = ~rd_ptr;
        end
        if (push && !pop) begin
            next_count = count + 2'h1;
        end else if (pop && !push) begin
            next_count = count - 2'h1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            mem[0] <= '0;
            mem[1] <= '0;
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end else if (ce_in) begin
            mem[0] <= next_mem[0];
            mem[1] <= next_mem[1];
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end
endmodule

`default_nettype wire

// ### src/dbm_mapper.sv
`timescale 1ns/1ps
`default_nettype none
`include "dbm_defs.svh"

module dbm_mapper #(
    parameter int FRAME_CYCLES = `DBM_FRAME_NS / `DBM_CLK_NS
) (
    input wire logic sys_clk_in, // System clock, 100 MHz.
    input wire logic srst_in, // Synchronous reset, active high.
    input wire logic ce_in, // Clock enable; low freezes all state.
    input wire logic ds3_bit_in, // Incoming DS3 bit.
    input wire logic ds3_valid_in, // DS3 bit present.
    output logic ds3_ready_out, // Elastic store has room.
    output logic spe_bit_out, // Envelope bit.
    output dbm_pkg::dbm_kind_type spe_kind_out, // Kind of envelope bit.
    output logic spe_valid_out, // Envelope bit present.
    input wire logic spe_ready_in, // Framer takes the bit.
    output logic spe_start_out, // Pulse: envelope begins.
    output logic [2:0] spe_opp_data_out, // Opportunities carrying data now.
    input wire logic dmp_bit_in, // Received envelope bit.
    input wire logic dmp_valid_in, // Received bit present.
    input wire logic dmp_sof_in, // Received bit is first of envelope.
    output logic dmp_bit_out, // Recovered DS3 bit.
    output logic dmp_valid_out, // Recovered bit present.
    output logic [12:0] dmp_count_out // DS3 bits of last envelope.
);
    import dbm_pkg::*;

    // =====================================================================
    // Frame pacing and elastic store.
    logic [13:0] timer, next_timer;
    logic pending, next_pending;
    logic frame_tick;
    logic mem [0:`DBM_STORE_DEPTH-1];
    logic [`DBM_STORE_AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [`DBM_STORE_AW:0] fill, next_fill;
    logic store_wr, store_rd;

    // =====================================================================
    // Envelope emission.
    dbm_map_state_type state, next_state;
    logic [3:0] row, next_row;
    logic [9:0] col, next_col;
    logic [2:0] n_opp, next_n_opp;
    logic [12:0] env_data, next_env_data;
    logic item_valid, item_bit, item_push, item_last, uses_data, buf_ready, start;
    dbm_kind_type item_kind;

    assign frame_tick = (timer == 14'(FRAME_CYCLES - 1));
    assign ds3_ready_out = (fill != 7'(`DBM_STORE_DEPTH));
    assign store_wr = ds3_valid_in && ds3_ready_out;
    assign start = pending && (state == MAP_IDLE);
    assign spe_start_out = start;
    assign spe_opp_data_out = n_opp;

    always_comb begin
        item_bit = 1'b0;
        uses_data = 1'b0;
        item_kind = KIND_DATA;
        if (col < 10'(`DBM_CTRL_BITS)) begin
            item_kind = KIND_CTRL;
            item_bit = !(row < {1'b0, n_opp});
        end else if (col == 10'(`DBM_OPP_COL)) begin
            if (row < {1'b0, n_opp}) begin
                item_kind = KIND_OPP_DATA;
                uses_data = 1'b1;
                item_bit = mem[rd_ptr];
            end else begin
                item_kind = KIND_OPP_STUFF;
            end
        end else begin
            uses_data = 1'b1;
            item_bit = mem[rd_ptr];
        end
        // A bit waits for the store rather than inventing data.
        item_valid = (state == MAP_RUN) && (!uses_data || fill != 7'h00);
        item_push = item_valid && buf_ready;
        item_last = (row == 4'(`DBM_ROWS - 1)) && (col == 10'(`DBM_ROW_LEN - 1));
        store_rd = item_push && uses_data;
    end

    always_comb begin
        next_timer = frame_tick ? 14'h0000 : timer + 14'h0001;
        next_pending = (pending && !start) || frame_tick;
        next_wr_ptr = store_wr ? wr_ptr + 6'h01 : wr_ptr;
        next_rd_ptr = store_rd ? rd_ptr + 6'h01 : rd_ptr;
        next_fill = fill + 7'(store_wr) - 7'(store_rd);
        next_state = state;
        next_row = row;
        next_col = col;
        next_n_opp = n_opp;
        next_env_data = env_data;
        if (start) begin
            next_state = MAP_RUN;
            next_row = 4'h0;
            next_col = 10'h000;
            next_env_data = 13'h0000;
            if (fill >= `DBM_STORE_HALF + `DBM_STORE_BAND) begin
                next_n_opp = `DBM_OPP_NEG;
            end else if (fill <= `DBM_STORE_HALF - `DBM_STORE_BAND) begin
                next_n_opp = `DBM_OPP_POS;
            end else begin
                next_n_opp = `DBM_OPP_NOMINAL;
            end
        end else if (item_push) begin
            next_env_data = env_data + 13'(uses_data);
            if (item_last) begin
                next_state = MAP_IDLE;
            end else if (col == 10'(`DBM_ROW_LEN - 1)) begin
                next_col = 10'h000;
                next_row = row + 4'h1;
            end else begin
                next_col = col + 10'h001;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            timer <= 14'h0000;
            pending <= 1'b0;
            wr_ptr <= 6'h00;
            rd_ptr <= 6'h00;
            fill <= 7'h00;
            state <= MAP_IDLE;
            row <= 4'h0;
            col <= 10'h000;
            n_opp <= `DBM_OPP_NOMINAL;
            env_data <= 13'h0000;
        end else if (ce_in) begin
            timer <= next_timer;
            pending <= next_pending;
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            fill <= next_fill;
            state <= next_state;
            row <= next_row;
            col <= next_col;
            n_opp <= next_n_opp;
            env_data <= next_env_data;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (ce_in && store_wr) begin
            mem[wr_ptr] <= ds3_bit_in;
        end
    end

    logic [`DBM_WORD_W-1:0] buf_out;

    dbm_pair_buffer u_buf (
        .sys_clk_in(sys_clk_in),
        .srst_in(srst_in),
        .ce_in(ce_in),
        .in_data_in({item_kind, item_bit}),
        .in_valid_in(item_valid),
        .in_ready_out(buf_ready),
        .out_data_out(buf_out),
        .out_valid_out(spe_valid_out),
        .out_ready_in(spe_ready_in)
    );

    assign spe_bit_out = buf_out[0];
    assign spe_kind_out = dbm_kind_type'(buf_out[2:1]);

    // =====================================================================
    // Demapper: mirrors the row layout and votes on the control bits.
    logic [3:0] drow, next_drow;
    logic [9:0] dcol, next_dcol;
    logic [2:0] ones, next_ones;
    logic [12:0] dcount, next_dcount, next_dmp_count;
    logic next_dmp_bit, next_dmp_valid;
    logic [9:0] pos_col;
    logic [3:0] pos_row;

    always_comb begin
        pos_col = dmp_sof_in ? 10'h000 : dcol;
        pos_row = dmp_sof_in ? 4'h0 : drow;
        next_drow = drow;
        next_dcol = dcol;
        next_ones = ones;
        next_dcount = dcount;
        next_dmp_count = dmp_count_out;
        next_dmp_bit = dmp_bit_out;
        next_dmp_valid = 1'b0;
        if (dmp_valid_in) begin
            if (dmp_sof_in) begin
                next_dmp_count = dcount;
                next_dcount = 13'h0000;
            end
            if (pos_col < 10'(`DBM_CTRL_BITS)) begin
                next_ones = ((pos_col == 10'h000) ? 3'h0 : ones) + 3'(dmp_bit_in);
            end else if (pos_col > 10'(`DBM_OPP_COL) || ones < 3'h3) begin
                next_dmp_valid = 1'b1;
                next_dmp_bit = dmp_bit_in;
                next_dcount = (dmp_sof_in ? 13'h0000 : dcount) + 13'h0001;
            end
            if (pos_col == 10'(`DBM_ROW_LEN - 1)) begin
                next_dcol = 10'h000;
                next_drow = (pos_row == 4'(`DBM_ROWS - 1)) ? 4'h0 : pos_row + 4'h1;
            end else begin
                next_dcol = pos_col + 10'h001;
                next_drow = pos_row;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            drow <= 4'h0;
            dcol <= 10'h000;
            ones <= 3'h0;
            dcount <= 13'h0000;
            dmp_count_out <= 13'h0000;
            dmp_bit_out <= 1'b0;
            dmp_valid_out <= 1'b0;
        end else if (ce_in) begin
            drow <= next_drow;
            dcol <= next_dcol;
            ones <= next_ones;
            dcount <= next_dcount;
            dmp_count_out <= next_dmp_count;
            dmp_bit_out <= next_dmp_bit;
            dmp_valid_out <= next_dmp_valid;
        end
    end

    // =====================================================================
    // Checks.
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);

    frame_spacing_a: assert property (ce_in && frame_tick |=> !frame_tick [*8])
        else $error("frame ticks too close");
    env_total_a: assert property (ce_in && item_push && item_last
        |-> env_data + 13'(uses_data) == 13'(`DBM_FIXED_DATA) + 13'(n_opp))
        else $error("envelope data count wrong");
    nominal_pick_a: assert property (ce_in && start && fill > `DBM_STORE_HALF - `DBM_STORE_BAND
        && fill < `DBM_STORE_HALF + `DBM_STORE_BAND |=> n_opp == `DBM_OPP_NOMINAL)
        else $error("nominal stuffing not chosen");
    neg_pick_a: assert property (ce_in && start && fill >= `DBM_STORE_HALF + `DBM_STORE_BAND
        |=> n_opp == `DBM_OPP_NEG)
        else $error("negative stuffing not chosen");
    pos_pick_a: assert property (ce_in && start && fill <= `DBM_STORE_HALF - `DBM_STORE_BAND
        |=> n_opp == `DBM_OPP_POS)
        else $error("positive stuffing not chosen");
    store_bounds_a: assert property (ce_in && store_rd |-> fill != 7'h00 ##1 fill <= 7'(`DBM_STORE_DEPTH))
        else $error("elastic store under or overrun");
    demap_out_a: assert property (ce_in && dmp_valid_in && !dmp_sof_in && dcol > 10'(`DBM_OPP_COL)
        |=> dmp_valid_out && dmp_bit_out == $past(dmp_bit_in))
        else $error("demapped data bit lost");
    row_shape_a: assert property (ce_in && item_push && col == 10'(`DBM_OPP_COL)
        |-> item_kind != KIND_DATA && item_kind != KIND_CTRL)
        else $error("opportunity slot misplaced");
    ctrl_code_a: assert property (ce_in && item_push && item_kind == KIND_CTRL
        |-> item_bit == (row >= {1'b0, n_opp}))
        else $error("control bits disagree with opportunity");

    neg_env_c: cover property (ce_in && start && fill >= `DBM_STORE_HALF + `DBM_STORE_BAND);
    pos_env_c: cover property (ce_in && start && fill <= `DBM_STORE_HALF - `DBM_STORE_BAND);
    env_done_c: cover property (ce_in && item_push && item_last);
    stall_c: cover property (spe_valid_out && !spe_ready_in ##1 !buf_ready);
endmodule

`default_nettype wire

// ### dv/dbm_far_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "dbm_defs.svh"

// =====================================================
// DS3 source and envelope framer with loopback.
module dbm_far_model (
    input wire logic sys_clk_in, // System clock.
    input wire logic srst_in, // Synchronous reset.
    input wire logic [6:0] target_in, // Store fill to aim at.
    input wire logic stall_in, // Framer refuses bits.
    output logic ds3_bit_out, // DS3 bit offered.
    output logic ds3_valid_out, // DS3 bit present.
    input wire logic ds3_ready_in, // Store has room.
    input wire logic spe_bit_in, // Envelope bit.
    input wire dbm_pkg::dbm_kind_type spe_kind_in, // Kind of envelope bit.
    input wire logic spe_valid_in, // Envelope bit present.
    output logic spe_ready_out, // Framer takes the bit.
    output logic dmp_bit_out, // Looped envelope bit.
    output logic dmp_valid_out, // Looped bit present.
    output logic dmp_sof_out // Looped bit starts an envelope.
);
    import dbm_pkg::*;
    localparam int ENV_LEN = `DBM_ROWS * `DBM_ROW_LEN;
    int acc, emit, pos;
    logic [7:0] seq;
    logic hs_q, bit_q, sof_q, want;

    // The source offers bits only while its estimate of the store fill is below target.
    always_comb want = !srst_in && (acc - emit < int'(target_in));

    always @(posedge sys_clk_in) begin
        hs_q <= spe_valid_in && spe_ready_out;
        bit_q <= spe_bit_in;
        sof_q <= (pos == 0);
        if (srst_in) begin
            acc <= 0;
            emit <= 0;
            pos <= 0;
            seq <= 8'h00;
        end else begin
            if (ds3_valid_out && ds3_ready_in) begin
                acc <= acc + 1;
                seq <= seq + 8'h01;
            end
            if (spe_valid_in && spe_ready_out) begin
                pos <= (pos == ENV_LEN - 1) ? 0 : pos + 1;
                if (spe_kind_in inside {KIND_DATA, KIND_OPP_DATA}) begin
                    emit <= emit + 1;
                end
            end
        end
    end

    // Idle lines toggle so that a stale value is never mistaken for data.
    always @(negedge sys_clk_in) begin
        ds3_valid_out <= want;
        ds3_bit_out <= want ? (seq[0] ^ seq[3] ^ seq[6]) : !ds3_bit_out;
        spe_ready_out <= !stall_in;
        dmp_valid_out <= hs_q;
        dmp_bit_out <= hs_q ? bit_q : !dmp_bit_out;
        dmp_sof_out <= hs_q && sof_q;
    end
endmodule
`default_nettype wire

// ### dv/ds3_sts1_bit_stuff_mapper_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dbm_defs.svh"

module ds3_sts1_bit_stuff_mapper_bench;
    import dbm_pkg::*;
    localparam int FRAME = 6000;
    localparam int ENV_LEN = `DBM_ROWS * `DBM_ROW_LEN;
    logic sys_clk_in, srst_in, ce, stall, ds3_bit, ds3_valid, ds3_ready, spe_bit, spe_valid, spe_ready, spe_start;
    logic d_bit, d_valid, d_sof, rec_bit, rec_valid;
    dbm_kind_type spe_kind;
    logic [2:0] opp, exp_n;
    logic [12:0] rec_cnt;
    logic [6:0] target;
    int error_cnt, compares, cycles, pos, row, col, nbits, env, since, frozen;
    logic [2:0] hist [16];
    logic q_map [$];
    logic q_dmp [$];

    dbm_mapper #(.FRAME_CYCLES(FRAME)) uut (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .ce_in(ce),
        .ds3_bit_in(ds3_bit), .ds3_valid_in(ds3_valid), .ds3_ready_out(ds3_ready), .spe_bit_out(spe_bit),
        .spe_kind_out(spe_kind), .spe_valid_out(spe_valid), .spe_ready_in(spe_ready),
        .spe_start_out(spe_start), .spe_opp_data_out(opp), .dmp_bit_in(d_bit), .dmp_valid_in(d_valid),
        .dmp_sof_in(d_sof), .dmp_bit_out(rec_bit), .dmp_valid_out(rec_valid), .dmp_count_out(rec_cnt));

    dbm_far_model far (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .target_in(target), .stall_in(stall),
        .ds3_bit_out(ds3_bit), .ds3_valid_out(ds3_valid), .ds3_ready_in(ds3_ready), .spe_bit_in(spe_bit),
        .spe_kind_in(spe_kind), .spe_valid_in(spe_valid), .spe_ready_out(spe_ready),
        .dmp_bit_out(d_bit), .dmp_valid_out(d_valid), .dmp_sof_out(d_sof));

    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // =====================================================
    // Envelope layout, bit order and recovered stream.
    always @(posedge sys_clk_in) begin
        since++;
        if (srst_in) begin
            pos = 0;
            since = -1;
        end else begin
            if (ds3_valid && ds3_ready) begin
                q_map.push_back(ds3_bit);
                q_dmp.push_back(ds3_bit);
            end
            if (rec_valid) cmp_val(16'(rec_bit), 16'(q_dmp.pop_front()), "recovered bit");
            if (spe_start) begin
                if (since > 0 && env > 0) cmp_val(16'(since), 16'(FRAME + frozen), "frame period");
                since = 0;
                frozen = 0;
                pos = 0;
                nbits = 0;
            end
            if (spe_valid && spe_ready) begin
                row = pos / `DBM_ROW_LEN;
                col = pos % `DBM_ROW_LEN;
                if (col < `DBM_CTRL_BITS) begin
                    cmp_val(16'(spe_kind), 16'(KIND_CTRL), "control kind");
                    cmp_val(16'(spe_bit), 16'(row >= int'(exp_n)), "control bit");
                end else if (col == `DBM_OPP_COL) begin
                    cmp_val(16'(spe_kind), 16'(row < int'(exp_n) ? KIND_OPP_DATA : KIND_OPP_STUFF), "opp kind");
                    if (row >= int'(exp_n)) cmp_val(16'(spe_bit), 16'h0000, "stuff bit");
                end else begin
                    cmp_val(16'(spe_kind), 16'(KIND_DATA), "data kind");
                end
                if (spe_kind inside {KIND_DATA, KIND_OPP_DATA}) begin
                    nbits++;
                    cmp_val(16'(spe_bit), 16'(q_map.pop_front()), "mapped bit");
                end
                pos++;
                if (pos == ENV_LEN) cmp_val(16'(nbits), 16'(`DBM_FIXED_DATA + exp_n), "bits per envelope");
            end
        end
    end

    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles > 45000) begin
            error_cnt++;
            print_verdict();
        end
    end

    task automatic t_reset();
        cmp_val(16'(opp), 16'h0003, "opp after reset");
        cmp_val(16'(spe_valid), 16'h0000, "valid after reset");
        cmp_val(16'(ds3_ready), 16'h0001, "ready after reset");
    endtask

    // Freezes the block while idle with a full store; ready and valid must stay low, and the first envelope's period allows for the 20 frozen cycles.
    task automatic t_freeze();
        target = 7'h40;
        repeat (200) @(negedge sys_clk_in);
        ce = 1'b0;
        frozen = 20;
        repeat (20) @(negedge sys_clk_in);
        cmp_val(16'(ds3_ready), 16'h0000, "frozen full store");
        cmp_val(16'(spe_valid), 16'h0000, "frozen idle output");
        ce = 1'b1;
    endtask

    // Aims the store fill at a level, then checks the choice made at the next envelope start.
    task automatic t_env(input logic [6:0] tgt, input logic [2:0] n, input bit stall_it);
        int w;
        target = tgt;
        w = 0;
        while (spe_start !== 1'b1 && w < 2 * FRAME) begin
            @(negedge sys_clk_in);
            w++;
        end
        exp_n = n;
        hist[env] = n;
        if (env >= 2) cmp_val(16'(rec_cnt), 16'(`DBM_FIXED_DATA + hist[env-2]), "demapped count");
        env++;
        // The choice is registered at the edge that ends the start pulse.
        @(negedge sys_clk_in);
        cmp_val(16'(opp), 16'(n), "opportunities used");
        if (tgt == 7'h40) cmp_val(16'(ds3_ready), 16'h0000, "full store refuses");
        if (stall_it) begin
            repeat (2000) @(negedge sys_clk_in);
            stall = 1'b1;
            repeat (50) @(negedge sys_clk_in);
            cmp_val(16'(spe_valid), 16'h0001, "word held in stall");
            stall = 1'b0;
        end
    endtask

    initial begin
        srst_in = 1'b1;
        ce = 1'b1;
        frozen = 0;
        stall = 1'b0;
        target = 7'h00;
        exp_n = 3'h3;
        error_cnt = 0;
        compares = 0;
        cycles = 0;
        env = 0;
        repeat (3) @(negedge sys_clk_in);
        t_reset();
        srst_in = 1'b0;
        t_freeze();
        t_env(7'h40, 3'h4, 1'b0);
        t_env(7'h24, 3'h3, 1'b0);
        t_env(7'h0A, 3'h2, 1'b1);
        t_env(7'h24, 3'h3, 1'b0);
        t_env(7'h40, 3'h4, 1'b0);
        t_env(7'h24, 3'h3, 1'b0);
        repeat (20) @(negedge sys_clk_in);
        print_verdict();
    end
endmodule
`default_nettype wire
